// >>> common/aoc_map.svh
// named offsets, field positions and timing figures for the output channel control
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH
// clock and timing
`define AOC_CLK_NS 8
`define AOC_NS_PER_US 1000
`define AOC_US_PER_S 1000000
`define AOC_RPI_US 1000
// data width and scale
`define AOC_DW 16
`define AOC_FS_SPAN 65536
`define AOC_POS_FS 32767
`define AOC_HOLD_PER_MILLE 1
`define AOC_PER_MILLE 1000
`define AOC_MA_FS_UA 20000
`define AOC_OW_MIN_UA 100
// channel status word bit positions
`define AOC_SB_HI 0
`define AOC_SB_LO 1
`define AOC_SB_RAMP 2
`define AOC_SB_HOLD 3
`define AOC_SB_CALF 4
`define AOC_SB_OPEN 7
// module fault summary word bit positions
`define AOC_MF_CALF 11
`define AOC_MF_CALIB 13
`define AOC_MF_GROUP 15
// fault word values
`define AOC_CF_COMM 16'hffff
`define AOC_WORD_ZERO 16'h0000
`endif

// >>> common/aoc_pkg.sv
// types shared by the output channel control design
package aoc_pkg;
  typedef logic [15:0] aoc_word_t;
  typedef enum logic [3:0]
  {
    aoc_st_wait = 4'b0001,
    aoc_st_run = 4'b0010,
    aoc_st_prog = 4'b0100,
    aoc_st_fault = 4'b1000
  } aoc_mode_t;
endpackage

// >>> rtl/aoc_chan_ctrl.sv
// per-channel output conditioning: ramping, hold, clamping, open wire and fault reporting
`timescale 1ns/1ps
`include "aoc_map.svh"
// Contract
// - in run mode with ramping on, output moves toward new level at most ramp rate
// - run mode ramping works only in floating point format
// - a program command ramps the output from present value to program value
// - a communications fault ramps the output from present value to fault value
// - the ramp rate setting counts engineering units per second
// - with hold selected, output stays until command is within 0.1% of full scale
// - hold starts on first connection, reconnection after fault, program to run
// - holding flag is set while a channel holds and cleared when hold ends
// - open wire is checked only on channels set for the 0-20mA range
// - open wire is flagged only once the applied output is at least 0.1mA, then stays set until wiring is restored
// - an open wire at a channel sets that channel's open wire status bit
// - in run mode in floating point format, output is kept between the channel's low and high clamp
// - a value past a clamp drives the clamp and sets high or low alarm
// - a clamp violation is reported to the controller by a status bit
// - clamp alarms can be disabled or latched per channel
// - clamping works only in floating point format
// - limit alarms work only in floating point format
// - echo values equal the value applied to each channel at that moment
// - echo, fault and status are sent once per packet interval
// - a module fault summary word covers all fault conditions; the ramp alarm does not reach it or the channel fault word
// - channel fault word has one bit per channel; each channel has a status word
// - on a communications fault every channel fault word bit reads set, ffff
module aoc_chan_ctrl #(
  parameter int N_CH = 8,
  parameter int RPI_US = `AOC_RPI_US,
  parameter int RPI_CYC = RPI_US * `AOC_NS_PER_US / `AOC_CLK_NS
) (
  input wire logic clk_sys_i, // system clock, 125 MHz
  input wire logic nrst_i, // sync reset, active low
  input wire logic fp_mode_i, // 1 floating point format, 0 integer
  input wire logic conn_ok_i, // connection with controller is up
  input wire logic prog_cmd_i, // controller is in program mode
  input wire logic comm_fault_i, // communications fault present
  input wire logic hold_init_en_i, // hold for initialization selected
  input wire logic run_ramp_en_i, // run mode ramping enabled
  input wire logic [`AOC_DW-1:0] ramp_rate_i, // max rate, codes per second
  input wire logic [N_CH*`AOC_DW-1:0] cmd_val_i, // commanded values
  input wire logic [N_CH*`AOC_DW-1:0] prog_val_i, // program values
  input wire logic [N_CH*`AOC_DW-1:0] fault_val_i, // fault values
  input wire logic [N_CH*`AOC_DW-1:0] clamp_hi_i, // high clamps
  input wire logic [N_CH*`AOC_DW-1:0] clamp_lo_i, // low clamps
  input wire logic [N_CH-1:0] alarm_dis_i, // alarms disabled per channel
  input wire logic [N_CH-1:0] alarm_latch_i, // alarms latching per channel
  input wire logic [N_CH-1:0] alarm_unlatch_i, // unlatch pulse per channel
  input wire logic [N_CH-1:0] range_ma_i, // channel in 0-20mA range
  input wire logic [N_CH-1:0] no_current_i, // pin: no loop current sensed
  input wire logic calibrating_i, // a channel is being calibrated
  input wire logic [N_CH-1:0] cal_fault_i, // calibration fault per channel
  output logic [N_CH*`AOC_DW-1:0] dac_val_o, // applied output values
  output logic [N_CH*`AOC_DW-1:0] echo_val_o, // data echo
  output logic echo_valid_o, // pulse: new report words
  output aoc_pkg::aoc_word_t module_fault_summary_word_o, // summary word
  output aoc_pkg::aoc_word_t per_channel_fault_word_o, // channel fault word
  output logic [N_CH*`AOC_DW-1:0] channel_detail_status_word_o, // status words
  output logic [N_CH-1:0] channel_holding_flag_o // channel is holding
);
  import aoc_pkg::*;

  localparam int DW = `AOC_DW;
  localparam logic [DW:0] HOLD_BAND =
    (DW+1)'(`AOC_FS_SPAN * `AOC_HOLD_PER_MILLE / `AOC_PER_MILLE);
  localparam logic signed [DW-1:0] OW_MIN =
    DW'(`AOC_POS_FS * `AOC_OW_MIN_UA / `AOC_MA_FS_UA);

  if (N_CH < 1 || N_CH > 16)
  begin : g_bad_nch
    $error("aoc_chan_ctrl: N_CH must be 1 to 16");
  end

  // ********************************
  // helper functions
  // ********************************
  // distance between two signed values
  function automatic logic [DW:0] abs_diff(input logic signed [DW-1:0] a,
                                           input logic signed [DW-1:0] b);
    logic [DW:0] d;
    d = {a[DW-1], a} - {b[DW-1], b};
    return d[DW] ? (DW+1)'(~d + 1'b1) : d;
  endfunction

  // codes per second times update period, at least one code
  function automatic logic [DW-1:0] step_calc(input logic [DW-1:0] rate);
    logic [63:0] p;
    p = 64'(rate) * 64'(RPI_US) / 64'(`AOC_US_PER_S);
    if (p == 64'h0)
      return DW'(1);
    else if (p > 64'({DW{1'b1}}))
      return {DW{1'b1}};
    else
      return DW'(p);
  endfunction

  // ********************************
  // declarations
  // ********************************
  aoc_mode_t mode_reg;
  aoc_mode_t mode_next;
  logic tick;
  logic enter_hold;
  logic ramp_on;
  logic [DW-1:0] step_val;
  logic signed [DW-1:0] cmd_s [N_CH];
  logic signed [DW-1:0] hi_s [N_CH];
  logic signed [DW-1:0] lo_s [N_CH];
  logic signed [DW-1:0] tgt_s [N_CH];
  logic signed [DW-1:0] nxt_s [N_CH];
  logic [N_CH-1:0] lim_s;
  logic [N_CH-1:0] req_hi;
  logic [N_CH-1:0] req_lo;
  logic signed [DW-1:0] out_reg [N_CH];
  logic signed [DW-1:0] out_next [N_CH];
  logic [N_CH-1:0] hold_reg, hold_next;
  logic [N_CH-1:0] busy_reg, busy_next;
  logic [N_CH-1:0] hi_al_reg, hi_al_next;
  logic [N_CH-1:0] lo_al_reg, lo_al_next;
  logic [N_CH-1:0] rp_al_reg, rp_al_next;
  logic [N_CH-1:0] ow_reg, ow_next;
  logic [N_CH-1:0] sync1_reg, sync2_reg, sync3_reg;
  logic [N_CH-1:0] ow_pin_reg, ow_pin_next;
  logic [N_CH*DW-1:0] echo_reg, echo_next;
  logic [N_CH*DW-1:0] stat_reg, stat_next;
  aoc_word_t chf_reg, chf_next;
  aoc_word_t mfw_reg, mfw_next;
  logic valid_reg;

  // ********************************
  // packet interval divider and ramp steppers
  // ********************************
  aoc_tick_div #(
    .CYC(RPI_CYC)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .tick_o(tick)
  );

  for (genvar g = 0; g < N_CH; g++)
  begin : g_step
    aoc_ramp_step #(
      .DW(DW)
    ) u_step (
      .cur_i(out_reg[g]),
      .tgt_i(tgt_s[g]),
      .step_i(step_val),
      .lim_en_i(ramp_on && (ramp_rate_i != '0)),
      .nxt_o(nxt_s[g]),
      .limited_o(lim_s[g])
    );
  end

  // ********************************
  // connection mode
  // ********************************
  // mode next state
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      aoc_st_wait:
        if (conn_ok_i)
          mode_next = prog_cmd_i ? aoc_st_prog : aoc_st_run;
      aoc_st_run:
        if (comm_fault_i)
          mode_next = aoc_st_fault;
        else if (prog_cmd_i)
          mode_next = aoc_st_prog;
      aoc_st_prog:
        if (comm_fault_i)
          mode_next = aoc_st_fault;
        else if (!prog_cmd_i)
          mode_next = aoc_st_run;
      aoc_st_fault:
        if (conn_ok_i && !comm_fault_i)
          mode_next = prog_cmd_i ? aoc_st_prog : aoc_st_run;
      default:
        mode_next = aoc_st_wait;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      mode_reg <= aoc_st_wait;
    else
      mode_reg <= mode_next;
  end

  // every way into run: first link, relink after fault, program to run
  assign enter_hold = hold_init_en_i && (mode_next == aoc_st_run) &&
                      (mode_reg != aoc_st_run);
  assign ramp_on = (mode_reg != aoc_st_run) || (fp_mode_i && run_ramp_en_i);
  assign step_val = step_calc(ramp_rate_i);

  // ********************************
  // open wire pin synchroniser
  // ********************************
  // accept a change once second and third stage agree
  always_comb
  begin
    ow_pin_next = (sync2_reg & sync3_reg) | (ow_pin_reg & (sync2_reg ^ sync3_reg));
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      ow_pin_reg <= '0;
    end
    else
    begin
      sync1_reg <= no_current_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      ow_pin_reg <= ow_pin_next;
    end
  end

  // ********************************
  // channel datapath and alarms
  // ********************************
  // targets per mode, clamps only in floating point format
  always_comb
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      cmd_s[c] = $signed(cmd_val_i[c*DW +: DW]);
      hi_s[c] = $signed(clamp_hi_i[c*DW +: DW]);
      lo_s[c] = $signed(clamp_lo_i[c*DW +: DW]);
      req_hi[c] = fp_mode_i && (cmd_s[c] > hi_s[c]);
      req_lo[c] = fp_mode_i && (cmd_s[c] < lo_s[c]);
      case (mode_reg)
        aoc_st_run:
          if (hold_reg[c])
            tgt_s[c] = out_reg[c];
          else if (req_hi[c])
            tgt_s[c] = hi_s[c];
          else if (req_lo[c])
            tgt_s[c] = lo_s[c];
          else
            tgt_s[c] = cmd_s[c];
        aoc_st_prog:
          tgt_s[c] = $signed(prog_val_i[c*DW +: DW]);
        aoc_st_fault:
          tgt_s[c] = $signed(fault_val_i[c*DW +: DW]);
        default:
          tgt_s[c] = out_reg[c];
      endcase
    end
  end

  // next channel state
  always_comb
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      out_next[c] = tick ? nxt_s[c] : out_reg[c];
      hold_next[c] = enter_hold || (hold_reg[c] && (mode_next == aoc_st_run) &&
                     (abs_diff(cmd_s[c], out_reg[c]) > HOLD_BAND));
      busy_next[c] = tick ? ((mode_reg == aoc_st_run) && lim_s[c]) : busy_reg[c];
      // live cause sets unless alarms are disabled or format is integer, latch holds until unlatched
      hi_al_next[c] = !alarm_dis_i[c] && fp_mode_i && (req_hi[c] ||
        (alarm_latch_i[c] && hi_al_reg[c] && !alarm_unlatch_i[c]));
      lo_al_next[c] = !alarm_dis_i[c] && fp_mode_i && (req_lo[c] ||
        (alarm_latch_i[c] && lo_al_reg[c] && !alarm_unlatch_i[c]));
      rp_al_next[c] = !alarm_dis_i[c] && fp_mode_i && (busy_next[c] ||
        (alarm_latch_i[c] && rp_al_reg[c] && !alarm_unlatch_i[c]));
      // stays set until wiring restored
      ow_next[c] = range_ma_i[c] && ow_pin_reg[c] &&
                   ((out_reg[c] >= OW_MIN) || ow_reg[c]);
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      for (int c = 0; c < N_CH; c++)
        out_reg[c] <= '0;
      hold_reg <= '0;
      busy_reg <= '0;
      hi_al_reg <= '0;
      lo_al_reg <= '0;
      rp_al_reg <= '0;
      ow_reg <= '0;
    end
    else
    begin
      for (int c = 0; c < N_CH; c++)
        out_reg[c] <= out_next[c];
      hold_reg <= hold_next;
      busy_reg <= busy_next;
      hi_al_reg <= hi_al_next;
      lo_al_reg <= lo_al_next;
      rp_al_reg <= rp_al_next;
      ow_reg <= ow_next;
    end
  end

  // ********************************
  // report words, taken once per interval
  // ********************************
  always_comb
  begin
    echo_next = echo_reg;
    stat_next = stat_reg;
    chf_next = chf_reg;
    mfw_next = mfw_reg;
    if (tick)
    begin
      chf_next = `AOC_WORD_ZERO;
      for (int c = 0; c < N_CH; c++)
      begin
        echo_next[c*DW +: DW] = out_next[c];
        stat_next[c*DW +: DW] = '0;
        stat_next[c*DW + `AOC_SB_HI] = hi_al_next[c];
        stat_next[c*DW + `AOC_SB_LO] = lo_al_next[c];
        stat_next[c*DW + `AOC_SB_RAMP] = rp_al_next[c];
        stat_next[c*DW + `AOC_SB_HOLD] = hold_next[c];
        stat_next[c*DW + `AOC_SB_CALF] = cal_fault_i[c];
        stat_next[c*DW + `AOC_SB_OPEN] = ow_next[c];
        chf_next[c] = hi_al_next[c] || lo_al_next[c] || ow_next[c] ||
                      cal_fault_i[c];
      end
      if (calibrating_i)
        chf_next = aoc_word_t'({N_CH{1'b1}});
      if (comm_fault_i)
        chf_next = `AOC_CF_COMM;
      mfw_next = `AOC_WORD_ZERO;
      mfw_next[`AOC_MF_GROUP] = (chf_next != `AOC_WORD_ZERO);
      mfw_next[`AOC_MF_CALIB] = calibrating_i;
      mfw_next[`AOC_MF_CALF] = |cal_fault_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      echo_reg <= '0;
      stat_reg <= '0;
      chf_reg <= `AOC_WORD_ZERO;
      mfw_reg <= `AOC_WORD_ZERO;
      valid_reg <= 1'b0;
    end
    else
    begin
      echo_reg <= echo_next;
      stat_reg <= stat_next;
      chf_reg <= chf_next;
      mfw_reg <= mfw_next;
      valid_reg <= tick;
    end
  end

  // output wiring, all from flip-flops
  for (genvar g = 0; g < N_CH; g++)
  begin : g_out
    assign dac_val_o[g*DW +: DW] = out_reg[g];
  end
  assign echo_val_o = echo_reg;
  assign echo_valid_o = valid_reg;
  assign module_fault_summary_word_o = mfw_reg;
  assign per_channel_fault_word_o = chf_reg;
  assign channel_detail_status_word_o = stat_reg;
  assign channel_holding_flag_o = hold_reg;

  // ********************************
  // checks
  // ********************************
  chk_comm_fault_word: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tick && comm_fault_i |=> per_channel_fault_word_o == `AOC_CF_COMM)
    else $error("fault word not ffff on comm fault");
  chk_echo_applied: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    echo_valid_o |-> echo_val_o == dac_val_o) else $error("echo differs from output");
  chk_report_rate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tick |=> echo_valid_o ##1 !echo_valid_o) else $error("report not once per tick");
  chk_hold_entry: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    enter_hold |=> &channel_holding_flag_o) else $error("hold not entered");

  for (genvar g = 0; g < N_CH; g++)
  begin : g_chk
    chk_clamp_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      tick && mode_reg == aoc_st_run && !hold_reg[g] && !ramp_on && req_hi[g]
      |=> out_reg[g] == $past(hi_s[g])) else $error("output not at high clamp");
    chk_alarm_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      fp_mode_i && !alarm_dis_i[g] &&
      ($signed(cmd_val_i[g*DW +: DW]) > $signed(clamp_hi_i[g*DW +: DW]))
      |=> hi_al_reg[g]) else $error("high alarm missing");
    chk_int_no_alarm: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !fp_mode_i |=> !hi_al_reg[g] && !lo_al_reg[g]) else $error("alarm in integer format");
    chk_open_range: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !range_ma_i[g] |=> !ow_reg[g]) else $error("open wire outside mA range");
    chk_ramp_limit: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      tick && lim_s[g] |=> abs_diff(out_reg[g], $past(out_reg[g])) == {1'b0, $past(step_val)})
      else $error("ramp step wrong size");
    chk_int_no_ramp: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      tick && mode_reg == aoc_st_run && !fp_mode_i && !hold_reg[g]
      |=> out_reg[g] == $past(cmd_s[g])) else $error("integer run output ramped");
  end
endmodule

// >>> rtl/aoc_ramp_step.sv
// one rate-limited step of an output toward its target
`timescale 1ns/1ps
module aoc_ramp_step #(
  parameter int DW = 16
) (
  input wire logic signed [DW-1:0] cur_i, // present output
  input wire logic signed [DW-1:0] tgt_i, // wanted output
  input wire logic [DW-1:0] step_i, // largest allowed change
  input wire logic lim_en_i, // limit active
  output logic signed [DW-1:0] nxt_o, // next output
  output logic limited_o // step was cut short
);
  logic [DW:0] diff;
  logic [DW:0] mag;

  if (DW < 2)
  begin : g_bad_dw
    $error("aoc_ramp_step: DW too small");
  end

  // ********************************
  // step toward target, never past it
  // ********************************
  always_comb
  begin
    diff = {tgt_i[DW-1], tgt_i} - {cur_i[DW-1], cur_i};
    mag = diff[DW] ? (DW+1)'(~diff + 1'b1) : diff;
    limited_o = lim_en_i && (mag > {1'b0, step_i});
    if (!limited_o)
    begin
      nxt_o = tgt_i;
    end
    else if (diff[DW])
    begin
      nxt_o = DW'({cur_i[DW-1], cur_i} - {1'b0, step_i});
    end
    else
    begin
      nxt_o = DW'({cur_i[DW-1], cur_i} + {1'b0, step_i});
    end
  end
endmodule

// >>> rtl/aoc_tick_div.sv
// divider giving a one-cycle pulse once per packet update interval
`timescale 1ns/1ps
module aoc_tick_div #(
  parameter int CYC = 125000
) (
  input wire logic clk_sys_i, // system clock
  input wire logic nrst_i, // sync reset, active low
  output logic tick_o // one pulse per interval
);
  localparam int CW = (CYC < 2) ? 1 : $clog2(CYC);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  if (CYC < 2)
  begin : g_bad_cyc
    $error("aoc_tick_div: CYC must be at least 2");
  end

  // ********************************
  // interval counter
  // ********************************
  assign tick_o = (cnt_reg == CW'(CYC - 1));

  always_comb
  begin
    cnt_next = tick_o ? '0 : cnt_reg + 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  chk_tick_restart: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    tick_o |=> !tick_o && (cnt_reg == '0)) else $error("tick not followed by restart");
endmodule

// >>> verification/aoc_ctrl_model.sv
// owner controller model: connection, program and link-fault levels
`timescale 1ns/1ps
module aoc_ctrl_model (
  input wire logic clk_sys_i, // system clock
  input wire logic [1:0] link_state_i, // 0 idle, 1 run, 2 program, 3 lost
  output logic conn_ok_o, // connection up
  output logic prog_cmd_o, // program command
  output logic comm_fault_o // link lost
);
  logic [1:0] lvl;
  // nothing is connected until the bench asks for it, then
  // sample the request at each edge and drive shortly after it
  initial
  begin
    conn_ok_o = 1'b0;
    prog_cmd_o = 1'b0;
    comm_fault_o = 1'b0;
    forever
    begin
      @(posedge clk_sys_i);
      lvl = link_state_i;
      #1;
      conn_ok_o = (lvl == 2'd1) || (lvl == 2'd2);
      prog_cmd_o = (lvl == 2'd2);
      comm_fault_o = (lvl == 2'd3);
    end
  end
endmodule

// >>> verification/tb_aoc_chan_ctrl.sv
// self-checking bench for the output channel control block
`timescale 1ns/1ps
module tb_aoc_chan_ctrl;
  import aoc_pkg::*;
  localparam int RATE = 10000;
  localparam int STEP = RATE * 1000 / 1000000; // codes per interval
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic fp = 1'b0, hold_en = 1'b0, ramp_en = 1'b1, calib = 1'b0;
  logic [15:0] rate = 16'(RATE);
  logic [31:0] cmd = 32'h0, prog = 32'h0;
  logic [31:0] fval = {16'hfc18, 16'h0249};
  logic [31:0] hi = {16'h03e8, 16'h03e8}, lo = {16'hfc18, 16'hfc18};
  logic [1:0] dis = 2'b00, latch = 2'b00, unl = 2'b00, rng = 2'b01;
  logic [1:0] nocur = 2'b00, calf = 2'b00, state = 2'd0;
  logic conn, pcmd, cfault, ev;
  logic [31:0] dac, echo, stat;
  logic [1:0] hold;
  aoc_word_t mfw, cfw;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  aoc_ctrl_model ctl (.clk_sys_i(clk_sys_i), .link_state_i(state), .conn_ok_o(conn),
    .prog_cmd_o(pcmd), .comm_fault_o(cfault));

  aoc_chan_ctrl #(.N_CH(2), .RPI_US(1000), .RPI_CYC(16)) uut (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .fp_mode_i(fp), .conn_ok_i(conn), .prog_cmd_i(pcmd),
    .comm_fault_i(cfault), .hold_init_en_i(hold_en), .run_ramp_en_i(ramp_en),
    .ramp_rate_i(rate), .cmd_val_i(cmd), .prog_val_i(prog), .fault_val_i(fval),
    .clamp_hi_i(hi), .clamp_lo_i(lo), .alarm_dis_i(dis), .alarm_latch_i(latch),
    .alarm_unlatch_i(unl), .range_ma_i(rng), .no_current_i(nocur),
    .calibrating_i(calib), .cal_fault_i(calf), .dac_val_o(dac), .echo_val_o(echo),
    .echo_valid_o(ev), .module_fault_summary_word_o(mfw),
    .per_channel_fault_word_o(cfw), .channel_detail_status_word_o(stat),
    .channel_holding_flag_o(hold));

  // 125 MHz clock
  initial
  begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // wait for n report pulses, sampled just after the edge
  task automatic wait_rep(input int n);
    repeat (n)
    begin
      do
      begin
        @(posedge clk_sys_i);
        #1;
      end
      while (ev !== 1'b1);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      final_report();
    end
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(dac[15:0], 16'h0000);
    check(mfw, 16'h0000);
    nrst_i = 1'b1;
    // integer format, low current: no open wire yet
    cmd = {16'hfffb, 16'h0064};
    nocur = 2'b11;
    state = 2'd1;
    wait_rep(3);
    check(dac[15:0], 16'h0064);
    check(dac[31:16], 16'hfffb);
    check(stat[15:0], 16'h0000);
    cmd[15:0] = 16'h07d0;
    wait_rep(3);
    check(dac[15:0], 16'h07d0);
    check(echo[15:0], 16'h07d0);
    check(stat[15:0], 16'h0080);
    check(stat[31:16], 16'h0000);
    check(cfw, 16'h0001);
    check(mfw, 16'h8000);
    // floating point: clamping and limit alarms
    nocur = 2'b00;
    ramp_en = 1'b0;
    fp = 1'b1;
    cmd[31:16] = 16'hf448;
    wait_rep(4);
    check(dac[15:0], 16'h03e8);
    check(dac[31:16], 16'hfc18);
    check(stat[15:0], 16'h0001);
    check(stat[31:16], 16'h0002);
    check(cfw, 16'h0003);
    dis = 2'b01;
    wait_rep(2);
    check(stat[15:0], 16'h0000);
    check(cfw, 16'h0002);
    dis = 2'b00;
    latch = 2'b01;
    wait_rep(1);
    cmd[15:0] = 16'h01f4;
    wait_rep(2);
    check(dac[15:0], 16'h01f4);
    check(stat[15:0], 16'h0001);
    unl = 2'b01;
    @(posedge clk_sys_i);
    #1;
    unl = 2'b00;
    latch = 2'b00;
    wait_rep(1);
    check(stat[15:0], 16'h0000);
    // run mode ramping
    ramp_en = 1'b1;
    cmd[15:0] = 16'h0258;
    for (int k = 1; k <= 10; k++)
    begin
      wait_rep(1);
      check(dac[15:0], 16'(500 + STEP * k));
      if (k == 1)
        check(stat[15:0], 16'h0004);
    end
    wait_rep(1);
    check(dac[15:0], 16'h0258);
    check(stat[15:0], 16'h0000);
    // zero rate: no limit, new level lands at the next interval
    rate = 16'h0000;
    cmd[15:0] = 16'h02bc;
    wait_rep(1);
    check(dac[15:0], 16'h02bc);
    check(stat[15:0], 16'h0000);
    cmd[15:0] = 16'h0258;
    wait_rep(1);
    check(dac[15:0], 16'h0258);
    rate = 16'(RATE);
    // program command
    prog = {16'hfc18, 16'h0226};
    state = 2'd2;
    wait_rep(1);
    check(dac[15:0], 16'h024e);
    wait_rep(4);
    check(dac[15:0], 16'h0226);
    // program to run with hold: 66 codes away holds, 65 releases
    hold_en = 1'b1;
    cmd = {16'hfc18, 16'h0268};
    state = 2'd1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check(16'(hold[0]), 16'h0001);
    wait_rep(1);
    check(dac[15:0], 16'h0226);
    check(16'(hold[0]), 16'h0001);
    cmd[15:0] = 16'h0267;
    repeat (3) @(posedge clk_sys_i);
    #1;
    check(16'(hold[0]), 16'h0000);
    wait_rep(8);
    check(dac[15:0], 16'h0267);
    // link lost: ramp to fault value
    state = 2'd3;
    wait_rep(1);
    check(dac[15:0], 16'h025d);
    check(cfw, 16'hffff);
    wait_rep(3);
    check(dac[15:0], 16'h0249);
    // reconnect with hold, then calibration
    cmd[15:0] = 16'h0300;
    state = 2'd1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check(16'(hold[0]), 16'h0001);
    calib = 1'b1;
    calf = 2'b01;
    wait_rep(2);
    check(cfw, 16'h0003);
    check(mfw, 16'ha800);
    check(stat[15:0], 16'h0018);
    check(echo[15:0], 16'h0249);
    check(16'(ev), 16'h0001);
    @(posedge clk_sys_i);
    #1;
    check(16'(ev), 16'h0000);
    final_report();
  end
endmodule
